/* File: rtl/ppp_pkg.sv */
package ppp_pkg;
  // ----------------------------------------------------------------------
  // Port modes and control bits
  // ----------------------------------------------------------------------
  localparam logic MODE_COMPAT = 1'b0;  // Printer handshake mode
  localparam logic MODE_EPP    = 1'b1;  // Enhanced parallel mode
  localparam logic [7:0] DATA_RST_VAL = 8'h00;  // Data register reset value
  localparam logic [3:0] CTRL_RST_VAL = 4'h4;   // Reset request bit high: released
  localparam int CTRL_STROBE_BIT = 0;   // Data valid strobe enable
  localparam int CTRL_FEED_BIT   = 1;   // Line feed enable
  localparam int CTRL_RESET_BIT  = 2;   // Reset request: 1 floats the pin
  localparam int CTRL_CHOOSE_BIT = 3;   // Printer choose enable
  localparam int EPP_MAX_WAIT = 16;     // Wait cycles before a cycle is aborted

  // ----------------------------------------------------------------------
  // Pin groups
  // ----------------------------------------------------------------------
  typedef struct packed
  {
    logic [7:0] data_o;   // Data lines driven value
    logic       data_oe;  // Data lines driven
    logic       feed_o;   // Line feed / data cycle strobe pin
    logic       feed_oe;
    logic       choose_o; // Choose / address strobe pin
    logic       choose_oe;
    logic       stb_o;    // Data valid / write strobe pin
    logic       stb_oe;
    logic       rst_o;    // Reset request pin
    logic       rst_oe;
  } ppp_pins_t;

  typedef struct packed
  {
    logic busy;       // Printer busy or EPP wait (low)
    logic receipt_n;  // Receipt pulse, active low
    logic fault_n;    // Fault, active low
    logic media_exh;  // Out of paper
    logic online;     // Printer selected
  } ppp_stat_t;

  typedef enum {ST_IDLE, ST_STROBE, ST_EPP, ST_DONE} ppp_state_t;
endpackage

/* File: rtl/ppp_port.sv */
`timescale 1ns/1ps
// What this block does
// R1: Peripheral pulses receipt low per byte taken
// R2: Compat: feed low requests automatic line feed
// R3: Feed, choose, strobe float when bit 0; the code does this in compat mode only, EPP always drives them
// R4: Reset request low initializes; floats when 1
// R5: EPP: feed pin is data cycle strobe
// R6: Aborted EPP cycle returns strobes high
// R7: Peripheral holds busy high while not ready
// R8: EPP wait low stretches the cycle
// R9: Peripheral drives fault low on error
// R10: Peripheral drives media exhausted high when empty
// R11: Peripheral drives online high while selected
// R12: Compat: choose low selects the peripheral
// R13: EPP: choose pin is address strobe
// R14: Compat: strobe low marks valid data
// R15: EPP: strobe pin is write strobe
// R16: Data lines carry bytes both ways
// R17: Mode picks each shared pin role
module ppp_port
#(
  parameter int MAX_WAIT = ppp_pkg::EPP_MAX_WAIT
)
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               port_mode,       // 0 compat, 1 EPP
  input  wire logic [3:0]         ctrl_bits,       // Control register image
  input  wire logic [7:0]         wr_data,         // Byte to send
  input  wire logic               wr_is_addr,      // EPP: address cycle
  input  wire logic               wr_valid,
  output logic                    wr_ready,
  output logic [7:0]              rd_data,         // Byte read back from lines
  output logic                    rd_valid,
  input  wire logic               rd_ready,
  input  wire logic               rd_req,          // Sample lines as input byte
  input  wire logic [7:0]         port_data_lines_i,
  input  wire ppp_pkg::ppp_stat_t stat_i,
  output ppp_pkg::ppp_pins_t      pins,
  output ppp_pkg::ppp_stat_t      stat_q,          // Registered status
  output logic                    epp_abort        // Pulse: cycle timed out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed
  {
    ppp_pkg::ppp_state_t st;
    logic [7:0]          cnt;        // Wait counter
    logic [7:0]          out_byte;   // Byte on the lines
    logic                out_addr;
    ppp_pkg::ppp_pins_t  pins;
    ppp_pkg::ppp_stat_t  stat;
    logic                abort;
    logic [1:0][7:0]     buf_d;      // Two-entry read buffer
    logic [1:0]          buf_v;
    logic                wr_rdy;
  } ppp_st_t;

  ppp_st_t state_ff;
  ppp_st_t nxt_state;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic epp;
    epp = (port_mode == ppp_pkg::MODE_EPP);
    nxt_state = state_ff;
    nxt_state.abort = 1'b0;
    nxt_state.stat = stat_i;                        // R1 R7 R9 R10 R11
    // Buffer drain: oldest word leaves, second moves up
    if (state_ff.buf_v[0] && rd_ready)
    begin
      nxt_state.buf_d[0] = state_ff.buf_d[1];
      nxt_state.buf_v    = {1'b0, state_ff.buf_v[1]};
    end
    // Buffer fill once the lines are released and a slot is free; the
    // released check keeps our own driven byte out of the buffer
    if (rd_req && !state_ff.pins.data_oe && !nxt_state.buf_v[1])
    begin
      if (!nxt_state.buf_v[0])
      begin
        nxt_state.buf_d[0] = port_data_lines_i;     // R16
        nxt_state.buf_v[0] = 1'b1;
      end
      else
      begin
        nxt_state.buf_d[1] = port_data_lines_i;     // R16
        nxt_state.buf_v[1] = 1'b1;
      end
    end
    // Transfer sequencer
    case (state_ff.st)
      ppp_pkg::ST_IDLE:
      begin
        if (wr_valid && state_ff.wr_rdy)
        begin
          nxt_state.out_byte = wr_data;
          nxt_state.out_addr = wr_is_addr;
          nxt_state.cnt      = 8'h00;
          nxt_state.st       = epp ? ppp_pkg::ST_EPP : ppp_pkg::ST_STROBE;
        end
      end
      ppp_pkg::ST_STROBE:
      begin
        // Hold strobe until the printer is not busy
        if (!stat_i.busy)                           // R7
        begin
          nxt_state.st = ppp_pkg::ST_DONE;
        end
      end
      ppp_pkg::ST_EPP:
      begin
        if (stat_i.busy)                            // R8
        begin
          nxt_state.st = ppp_pkg::ST_DONE;
        end
        else if (state_ff.cnt == 8'(MAX_WAIT - 1))
        begin
          nxt_state.abort = 1'b1;                   // R6
          nxt_state.st    = ppp_pkg::ST_DONE;
        end
        else
        begin
          nxt_state.cnt = state_ff.cnt + 8'h01;     // R8
        end
      end
      default:
      begin
        nxt_state.st = ppp_pkg::ST_IDLE;
      end
    endcase
    nxt_state.wr_rdy = (nxt_state.st == ppp_pkg::ST_IDLE);
    // Pin drive: data lines driven out whenever not reading
    nxt_state.pins.data_o  = nxt_state.out_byte;   // R16
    nxt_state.pins.data_oe = !rd_req;              // R16
    if (epp)                                       // R17
    begin
      // EPP strobes are always driven, high when idle or aborted
      nxt_state.pins.feed_oe   = 1'b1;
      nxt_state.pins.choose_oe = 1'b1;
      nxt_state.pins.stb_oe    = 1'b1;
      nxt_state.pins.feed_o    = !(nxt_state.st == ppp_pkg::ST_EPP
                                   && !nxt_state.out_addr);      // R5 R6
      nxt_state.pins.choose_o  = !(nxt_state.st == ppp_pkg::ST_EPP
                                   && nxt_state.out_addr);       // R13 R6
      nxt_state.pins.stb_o     = !(nxt_state.st == ppp_pkg::ST_EPP); // R15 R6
    end
    else
    begin
      nxt_state.pins.feed_o    = 1'b0;                                // R2
      nxt_state.pins.feed_oe   = ctrl_bits[ppp_pkg::CTRL_FEED_BIT];   // R3
      nxt_state.pins.choose_o  = 1'b0;                                // R12
      nxt_state.pins.choose_oe = ctrl_bits[ppp_pkg::CTRL_CHOOSE_BIT]; // R3
      nxt_state.pins.stb_o     = !(nxt_state.st == ppp_pkg::ST_STROBE); // R14
      nxt_state.pins.stb_oe    = ctrl_bits[ppp_pkg::CTRL_STROBE_BIT]; // R3
    end
    nxt_state.pins.rst_o  = 1'b0;                                     // R4
    nxt_state.pins.rst_oe = !ctrl_bits[ppp_pkg::CTRL_RESET_BIT];      // R4
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_ff <= '0;
      state_ff.st <= ppp_pkg::ST_IDLE;
      state_ff.wr_rdy <= 1'b1;
      state_ff.out_byte <= ppp_pkg::DATA_RST_VAL;
      state_ff.pins.feed_o <= 1'b1;
      state_ff.pins.choose_o <= 1'b1;
      state_ff.pins.stb_o <= 1'b1;
      state_ff.pins.rst_o <= 1'b0;
      state_ff.pins.rst_oe <= ~ppp_pkg::CTRL_RST_VAL[ppp_pkg::CTRL_RESET_BIT];
      state_ff.stat <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign pins      = state_ff.pins;
  assign stat_q    = state_ff.stat;
  assign epp_abort = state_ff.abort;
  assign wr_ready  = state_ff.wr_rdy;
  assign rd_data   = state_ff.buf_d[0];
  assign rd_valid  = state_ff.buf_v[0];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  feed_float_a: assert property (@(posedge clk) disable iff (sys_rst) // R3
    ($past(port_mode) == 1'b0 && !$past(ctrl_bits[ppp_pkg::CTRL_FEED_BIT]))
    |-> !pins.feed_oe)
    else $error("feed pin driven while disabled");
  reset_float_a: assert property (@(posedge clk) disable iff (sys_rst) // R4
    $past(ctrl_bits[ppp_pkg::CTRL_RESET_BIT]) |-> !pins.rst_oe)
    else $error("reset pin driven while bit set");
  reset_drive_a: assert property (@(posedge clk) disable iff (sys_rst) // R4
    (!$past(ctrl_bits[ppp_pkg::CTRL_RESET_BIT]) && !$past(sys_rst))
    |-> (pins.rst_oe && !pins.rst_o))
    else $error("reset pin not low when enabled");
  epp_abort_a: assert property (@(posedge clk) disable iff (sys_rst) // R6
    (epp_abort && $past(port_mode)) |-> (pins.feed_o && pins.choose_o && pins.stb_o))
    else $error("strobes not high after abort");
  epp_stretch_a: assert property (@(posedge clk) disable iff (sys_rst) // R8
    (state_ff.st == ppp_pkg::ST_EPP && !stat_i.busy && !epp_abort
     && state_ff.cnt != 8'(MAX_WAIT - 1)) |=> state_ff.st == ppp_pkg::ST_EPP)
    else $error("cycle ended while wait low");
  compat_choose_a: assert property (@(posedge clk) disable iff (sys_rst) // R12
    ($past(port_mode) == 1'b0 && $past(ctrl_bits[ppp_pkg::CTRL_CHOOSE_BIT])
     && !$past(sys_rst)) |-> (pins.choose_oe && !pins.choose_o))
    else $error("choose not driven low");
  epp_write_a: assert property (@(posedge clk) disable iff (sys_rst) // R15
    (state_ff.st == ppp_pkg::ST_EPP && $past(port_mode)) |-> !pins.stb_o)
    else $error("write strobe not low in cycle");
  compat_stb_a: assert property (@(posedge clk) disable iff (sys_rst) // R14
    (state_ff.st == ppp_pkg::ST_STROBE && !$past(port_mode)) |-> !pins.stb_o)
    else $error("data strobe not low in cycle");
  read_release_a: assert property (@(posedge clk) disable iff (sys_rst) // R16
    rd_req |=> !pins.data_oe)
    else $error("data lines driven while reading");
  epp_data_a: assert property (@(posedge clk) disable iff (sys_rst) // R5
    (state_ff.st == ppp_pkg::ST_EPP && $past(port_mode) && !state_ff.out_addr)
    |-> !pins.feed_o)
    else $error("data cycle strobe not low in cycle");

endmodule

/* File: bench/ppp_periph.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Peripheral model on the far side of the port pins
// ----------------------------------------------------------------------
module ppp_periph
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               epp,        // Port runs in EPP mode
  input  wire logic [3:0]         hold,       // Cycles until the peripheral answers
  input  wire logic               stuck,      // Never release wait
  input  wire logic               fault_n,
  input  wire logic               media_exh,
  input  wire logic               online,
  input  wire logic [7:0]         rd_byte,    // Byte put on the lines when released
  input  wire ppp_pkg::ppp_pins_t pins,
  output logic [7:0]              lines,
  output ppp_pkg::ppp_stat_t      stat
);
  logic [3:0] cnt_ff;   // Cycles the strobe has been low, or busy has stood
  logic       busy_ff;  // Busy, or wait released in EPP
  logic       rcpt_ff;  // Receipt pulse, active low
  logic       seen_ff;  // Strobe was low last cycle
  logic       act;      // Strobe asserted by the port
  assign act = pins.stb_oe & ~pins.stb_o;
  // EPP: release wait after hold + 1 strobe cycles; compat: take the byte as the
  // strobe rises, stay busy for hold + 1 cycles, then pulse receipt
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_ff  <= 4'h0;
      busy_ff <= 1'b0;
      rcpt_ff <= 1'b1;
      seen_ff <= 1'b0;
    end
    else if (epp)
    begin
      seen_ff <= 1'b0;
      rcpt_ff <= 1'b1;
      if (act)
      begin
        cnt_ff  <= (cnt_ff == hold) ? cnt_ff : cnt_ff + 4'h1;
        busy_ff <= (cnt_ff == hold) && !stuck;
      end
      else
      begin
        cnt_ff  <= 4'h0;
        busy_ff <= 1'b0;
      end
    end
    else
    begin
      seen_ff <= act;
      rcpt_ff <= 1'b1;
      if (busy_ff && cnt_ff == hold)
      begin
        cnt_ff  <= 4'h0;
        busy_ff <= 1'b0;
        rcpt_ff <= 1'b0;
      end
      else if (busy_ff)
      begin
        cnt_ff <= cnt_ff + 4'h1;
      end
      else if (seen_ff && !act)
      begin
        cnt_ff  <= 4'h0;
        busy_ff <= 1'b1;
      end
    end
  end
  // Lines show the port's byte while it drives, else ours
  assign lines = pins.data_oe ? pins.data_o : rd_byte;
  assign stat  = {busy_ff, rcpt_ff, fault_n, media_exh, online};
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, sys_rst = 1, port_mode = 0, wr_is_addr = 0, wr_valid = 0;
  logic rd_ready = 0, rd_req = 0, stuck = 0, fault_n = 1, media_exh = 0, online = 0;
  logic [3:0] ctrl_bits = 4'h0, hold = 4'h3;
  logic [7:0] wr_data = 8'h00, rd_data, lines;
  logic wr_ready, rd_valid, epp_abort, abort_seen = 0;
  logic rcpt_seen = 0, busy_seen = 0;
  logic [7:0] rd_byte = 8'h5A;
  ppp_pkg::ppp_pins_t pins;
  ppp_pkg::ppp_stat_t stat_i, stat_q;
  int n_mismatch = 0, n_checks = 0, cyc = 0, k;
  // ----------------------------------------------------------------------
  // Clock, timeout and instances
  // ----------------------------------------------------------------------
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (epp_abort === 1'b1) abort_seen = 1'b1;
    if (stat_q.receipt_n === 1'b0 && port_mode === 1'b0) rcpt_seen = 1'b1;
    if (stat_q.busy === 1'b1 && port_mode === 1'b0) busy_seen = 1'b1;
    if (cyc == 4000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  ppp_port #(.MAX_WAIT(6)) ppp_port_i (.clk(clk), .sys_rst(sys_rst), .port_mode(port_mode),
    .ctrl_bits(ctrl_bits), .wr_data(wr_data), .wr_is_addr(wr_is_addr), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_req(rd_req), .port_data_lines_i(lines), .stat_i(stat_i), .pins(pins),
    .stat_q(stat_q), .epp_abort(epp_abort));
  ppp_periph ppp_periph_i (.clk(clk), .sys_rst(sys_rst), .epp(port_mode), .hold(hold),
    .stuck(stuck), .fault_n(fault_n), .media_exh(media_exh), .online(online),
    .rd_byte(rd_byte), .pins(pins), .lines(lines), .stat(stat_i));
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One write, then strobe, shared pins and return to idle are checked
  task automatic do_wr(input logic [7:0] d, input logic a, input logic ef, input logic ec);
    @(negedge clk);
    wr_data = d;
    wr_is_addr = a;
    wr_valid = 1'b1;
    @(negedge clk);
    wr_valid = 1'b0;
    k = 0;
    while (pins.stb_o !== 1'b0 && k < 4)
    begin
      @(negedge clk);
      k++;
    end
    chk("strobe low", 8'h00, {7'h0, pins.stb_o});
    chk("data out", d, pins.data_o);
    chk("feed pin", {7'h0, ef}, {7'h0, pins.feed_o});
    chk("choose pin", {7'h0, ec}, {7'h0, pins.choose_o});
    k = 0;
    while (wr_ready !== 1'b1 && k < 40)
    begin
      @(negedge clk);
      k++;
    end
    chk("strobe high", 8'h01, {7'h0, pins.stb_o});
    chk("ready back", 8'h01, {7'h0, wr_ready});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (10) @(negedge clk);
    chk("reset pin", 8'h00, {6'h0, pins.rst_oe, pins.rst_o});
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    chk("float enables", 8'h00, {5'h0, pins.feed_oe, pins.choose_oe, pins.stb_oe});
    chk("status idle", 8'h0C, {3'h0, stat_q});
    ctrl_bits = 4'h4;
    repeat (2) @(negedge clk);
    chk("reset float", 8'h00, {7'h0, pins.rst_oe});
    ctrl_bits = 4'hB;
    repeat (2) @(negedge clk);
    chk("feed driven", 8'h02, {6'h0, pins.feed_oe, pins.feed_o});
    chk("choose driven", 8'h02, {6'h0, pins.choose_oe, pins.choose_o});
    chk("reset driven", 8'h02, {6'h0, pins.rst_oe, pins.rst_o});
    do_wr(8'h3C, 1'b0, 1'b0, 1'b0);
    do_wr(8'h69, 1'b0, 1'b0, 1'b0);
    chk("receipt seen", 8'h01, {7'h0, rcpt_seen});
    chk("busy seen", 8'h01, {7'h0, busy_seen});
    port_mode = 1'b1;
    hold = 4'h2;
    do_wr(8'hC3, 1'b0, 1'b0, 1'b1);
    do_wr(8'h81, 1'b1, 1'b1, 1'b0);
    stuck = 1'b1;
    do_wr(8'hA5, 1'b0, 1'b0, 1'b1);
    chk("abort seen", 8'h01, {7'h0, abort_seen});
    chk("strobes idle", 8'h03, {6'h0, pins.feed_o, pins.choose_o});
    stuck = 1'b0;
    port_mode = 1'b0;
    rd_req = 1'b1;
    repeat (2) @(negedge clk);
    rd_byte = 8'h96;
    repeat (2) @(negedge clk);
    chk("lines released", 8'h00, {7'h0, pins.data_oe});
    chk("read valid", 8'h01, {7'h0, rd_valid});
    chk("read head", 8'h5A, rd_data);
    rd_req = 1'b0;
    rd_ready = 1'b1;
    @(negedge clk);
    chk("read second", 8'h96, rd_data);
    @(negedge clk);
    rd_ready = 1'b0;
    chk("read empty", 8'h00, {7'h0, rd_valid});
    fault_n = 1'b0;
    media_exh = 1'b1;
    online = 1'b1;
    repeat (2) @(negedge clk);
    chk("status", 8'h0B, {3'h0, stat_q});
    end_of_test();
  end
endmodule
